// ===== rtl/eeprom_host_pkg.sv
// Constants, types and sequence tables for the parallel EEPROM host
package eeprom_host_pkg;

  // ----------------------------------------------------------------
  // Widths and clock
  // ----------------------------------------------------------------
  localparam int ADDR_W = 17;          // Byte address pins
  localparam int DATA_W = 8;           // Data pins
  localparam int PAGE_BITS = 7;        // Byte-in-page address bits
  localparam int POLL_BIT = 7;         // Data bit used for polling
  localparam int CLK_PERIOD_NS = 10;   // 100 MHz system clock

  typedef logic [20:0] cnt_t;          // Holds the longest wait count
  typedef logic [2:0] seq_t;           // Command sequence step

  // ----------------------------------------------------------------
  // Timing figures and their cycle counts
  // ----------------------------------------------------------------
  localparam int T_WP_NS = 250;        // Least write pulse width
  localparam int T_AH_NS = 150;        // Least address hold after pulse
  localparam int T_ACC_NS = 250;       // Longest read access time
  localparam int T_BLC_US = 30;        // Longest byte-load window
  localparam int T_START_US = 100;     // Idle time that starts programming
  localparam int T_WC_MS = 15;         // Longest page program time
  localparam int WP_CYC = (T_WP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int AH_CYC = (T_AH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ACC_CYC = (T_ACC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SYNC_CYC = 2;         // Latency of the pin synchroniser
  localparam int BLC_CYC = T_BLC_US * 1000 / CLK_PERIOD_NS;
  localparam int START_CYC = (T_START_US * 1000 + CLK_PERIOD_NS - 1)
                             / CLK_PERIOD_NS;
  localparam int WC_CYC = T_WC_MS * 1000000 / CLK_PERIOD_NS;
  // Next byte must have its pulse done before the device window closes
  localparam int WIN_LIMIT_CYC = BLC_CYC - AH_CYC - WP_CYC - 4;

  // ----------------------------------------------------------------
  // Protection sequence addresses and data
  // ----------------------------------------------------------------
  localparam logic [16:0] SEQ_ADDR_A = 17'h0_5555;
  localparam logic [16:0] SEQ_ADDR_B = 17'h0_2aaa;
  localparam logic [7:0] SEQ_D_AA = 8'haa;
  localparam logic [7:0] SEQ_D_55 = 8'h55;
  localparam logic [7:0] SEQ_D_LOCK = 8'ha0;
  localparam logic [7:0] SEQ_D_ERASE = 8'h80;
  localparam logic [7:0] SEQ_D_UNLOCK = 8'h20;
  localparam seq_t PREFIX_LAST = 3'h2; // Last step of the lock prefix
  localparam seq_t UNLOCK_LAST = 3'h5; // Last step of the unlock string

  // User command codes
  typedef enum logic [1:0] {OP_READ, OP_LOAD, OP_LOCK, OP_UNLOCK} op_e;

  // Address of one sequence step
  function automatic logic [16:0] seq_addr(input seq_t idx);
    seq_addr = (idx == 3'h1 || idx == 3'h4) ? SEQ_ADDR_B : SEQ_ADDR_A;
  endfunction

  // Data of one sequence step; third step differs for unlock
  function automatic logic [7:0] seq_data(input logic unl, input seq_t idx);
    case (idx)
      3'h0, 3'h3: seq_data = SEQ_D_AA;
      3'h1, 3'h4: seq_data = SEQ_D_55;
      3'h2: seq_data = unl ? SEQ_D_ERASE : SEQ_D_LOCK;
      default: seq_data = SEQ_D_UNLOCK;
    endcase
  endfunction

endpackage

// ===== rtl/eeprom_pin_sync.sv
// Two-flop synchroniser for the device's data and ready/busy pins
`timescale 1ns/1ps
module eeprom_pin_sync #(
  parameter int W = 9
) (
  input logic clk,
  input logic nrst,
  input logic [W-1:0] d,
  output logic [W-1:0] q
);

  // ----------------------------------------------------------------
  // Sync stages
  // ----------------------------------------------------------------
  logic [W-1:0] meta_r; // First stage, read only by the second

  // Pins are asynchronous to CLK; only q feeds logic
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      meta_r <= '0;
      q <= '0;
    end else begin
      meta_r <= d;
      q <= meta_r;
    end
  end

endmodule

// ===== rtl/eeprom_host.sv
// Host controller driving a byte-wide page EEPROM through its pins
//
// Operation
// [R01] Page holds 1..128 bytes, low seven bits
// [R02] Next byte loaded inside the load window; code restarts the window count after a refused command
// [R03] Idle control lines start internal programming
// [R04] Programming ends within fifteen milliseconds
// [R05] Poll bit reads inverted while busy
// [R06] Ready/busy low while programming runs
// [R07] Strobe pulses wider than the noise limit
// [R08] No write with read enable low
// [R09] Address at strobe fall, data at rise
// [R10] Protect low blocks all programming
// [R11] Protect held high throughout programming
// [R12] Lock: three fixed bytes, then dummy write
// [R13] Unlock: six fixed bytes in order
// [R14] Locked writes need the three-byte prefix; code clears locked_r after a page closed by CMD_LAST
// [R15] Chip select high idles the device
`timescale 1ns/1ps
module eeprom_host #(
  parameter int START_CYC = eeprom_host_pkg::START_CYC, // Program start
  parameter int WC_CYC = eeprom_host_pkg::WC_CYC        // Program timeout
) (
  input logic CLK,
  input logic NRST,
  input logic CMD_VALID,
  input eeprom_host_pkg::op_e CMD_OP,
  input logic [16:0] CMD_ADDR,
  input logic [7:0] CMD_DATA,
  input logic CMD_LAST,
  input logic HW_PROTECT,
  output logic CMD_READY,
  output logic RSP_VALID,
  output logic [7:0] RSP_DATA,
  output logic RSP_ERR,
  output logic LOCKED,
  output logic [16:0] ADDR,
  output logic [7:0] DQ_O,
  output logic DQ_OE_N,
  input logic [7:0] DQ_I,
  output logic CE_N,
  output logic OE_N,
  output logic WE_N,
  output logic PROTECT_RESET_N,
  input logic RDY_BUSY_N
);

  // ----------------------------------------------------------------
  // State and storage
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    S_IDLE, S_WSETUP, S_WPULSE, S_WHOLD, S_WINDOW,
    S_PWAIT, S_RSETUP, S_PGAP
  } state_e;

  state_e state_r;                     // Main sequencer state
  eeprom_host_pkg::cnt_t cnt_r;        // Timer within a state
  eeprom_host_pkg::cnt_t tmo_r;        // Programming timeout counter
  eeprom_host_pkg::seq_t seq_r;        // Step within a command string
  logic pre_r;                         // Lock prefix in progress
  logic unl_r;                         // Unlock string in progress
  logic lk_set_r;                      // Lock takes hold after this byte
  logic poll_r;                        // Read is a completion poll
  logic last_r;                        // Current byte closes the page
  logic [16:0] uaddr_r;                // User byte address
  logic [7:0] udata_r;                 // User byte data
  logic [9:0] page_r;                  // Page of the open page load
  logic [7:0] lastd_r;                 // Last byte put on the pins
  logic ce_n_r, oe_n_r, we_n_r, dq_oe_n_r;
  logic [16:0] addr_r;
  logic [7:0] dq_r;
  logic ready_r, rsp_valid_r, rsp_err_r, locked_r, prot_r;
  logic [7:0] rsp_data_r;
  logic [8:0] pins_s;                  // Synchronised busy and data
  logic fire;                          // Command taken this cycle
  logic same_page;                     // Load hits the open page
  logic poll_done;                     // Programming seen complete

  assign fire = CMD_VALID && ready_r;
  assign same_page = CMD_OP == eeprom_host_pkg::OP_LOAD &&
    CMD_ADDR[16:eeprom_host_pkg::PAGE_BITS] == page_r; // R01
  // Device done once busy is released and bit 7 reads true data
  assign poll_done = pins_s[8] &&
    pins_s[eeprom_host_pkg::POLL_BIT] ==
    lastd_r[eeprom_host_pkg::POLL_BIT]; // R05 R06

  // ----------------------------------------------------------------
  // Pin synchroniser
  // ----------------------------------------------------------------
  eeprom_pin_sync #(.W(9)) u_sync (
    .clk(CLK),
    .nrst(NRST),
    .d({RDY_BUSY_N, DQ_I}),
    .q(pins_s)
  );

  // ----------------------------------------------------------------
  // Main sequencer with its pin registers
  // ----------------------------------------------------------------
  // Pins change together with the state, so each output is a flop
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      state_r <= S_IDLE;
      cnt_r <= '0;
      tmo_r <= '0;
      seq_r <= '0;
      {pre_r, unl_r, lk_set_r, poll_r, last_r} <= '0;
      uaddr_r <= '0;
      udata_r <= '0;
      page_r <= '0;
      lastd_r <= '0;
      {ce_n_r, oe_n_r, we_n_r, dq_oe_n_r} <= 4'hf;
      addr_r <= '0;
      dq_r <= '0;
      {rsp_valid_r, rsp_err_r, locked_r} <= '0;
      rsp_data_r <= '0;
    end else begin
      rsp_valid_r <= 1'b0;
      cnt_r <= cnt_r + 1'b1;
      unique case (state_r)
        // Chip select high keeps the device idle here
        S_IDLE: begin
          if (fire) begin // R15
            uaddr_r <= CMD_ADDR;
            udata_r <= CMD_DATA;
            last_r <= CMD_LAST;
            page_r <= CMD_ADDR[16:eeprom_host_pkg::PAGE_BITS];
            rsp_err_r <= 1'b0;
            ce_n_r <= 1'b0;
            if (CMD_OP == eeprom_host_pkg::OP_READ) begin
              poll_r <= 1'b0;
              addr_r <= CMD_ADDR;
              oe_n_r <= 1'b0;
              cnt_r <= '0;
              state_r <= S_RSETUP;
            end else begin
              // Locked device: each page opens with the prefix until a page closed by CMD_LAST clears locked_r
              pre_r <= CMD_OP == eeprom_host_pkg::OP_LOCK ||
                (CMD_OP == eeprom_host_pkg::OP_LOAD && locked_r); // R14
              unl_r <= CMD_OP == eeprom_host_pkg::OP_UNLOCK; // R13
              lk_set_r <= CMD_OP == eeprom_host_pkg::OP_LOCK; // R12
              seq_r <= '0;
              dq_oe_n_r <= 1'b0;
              if (CMD_OP == eeprom_host_pkg::OP_LOAD && !locked_r) begin
                addr_r <= CMD_ADDR;
                dq_r <= CMD_DATA;
              end else begin
                addr_r <= eeprom_host_pkg::seq_addr('0);
                dq_r <= eeprom_host_pkg::seq_data(
                  CMD_OP == eeprom_host_pkg::OP_UNLOCK, '0);
              end
              state_r <= S_WSETUP;
            end
          end
        end
        // Address and data settle with strobe high, read enable high
        S_WSETUP: begin
          we_n_r <= 1'b0; // R08 R09
          cnt_r <= '0;
          state_r <= S_WPULSE;
        end
        // Strobe held low far beyond the noise filter width
        S_WPULSE: begin
          if (cnt_r == eeprom_host_pkg::cnt_t'(
              eeprom_host_pkg::WP_CYC - 1)) begin // R07
            we_n_r <= 1'b1; // R09
            ce_n_r <= 1'b1;
            lastd_r <= dq_r;
            cnt_r <= '0;
            state_r <= S_WHOLD;
          end
        end
        // Address and data held after the rising edges
        S_WHOLD: begin
          if (cnt_r == eeprom_host_pkg::cnt_t'(
              eeprom_host_pkg::AH_CYC - 1)) begin
            cnt_r <= '0;
            if ((pre_r && seq_r != eeprom_host_pkg::PREFIX_LAST) ||
                (unl_r && seq_r != eeprom_host_pkg::UNLOCK_LAST)) begin
              // Next fixed byte of the string, strictly in order
              seq_r <= seq_r + 1'b1; // R12 R13
              addr_r <= eeprom_host_pkg::seq_addr(seq_r + 1'b1);
              dq_r <= eeprom_host_pkg::seq_data(unl_r, seq_r + 1'b1);
              ce_n_r <= 1'b0;
              state_r <= S_WSETUP;
            end else if (pre_r) begin
              // Prefix done: user byte, or the dummy write of a lock
              pre_r <= 1'b0; // R12 R14
              addr_r <= uaddr_r;
              dq_r <= udata_r;
              ce_n_r <= 1'b0;
              state_r <= S_WSETUP;
            end else begin
              dq_oe_n_r <= 1'b1;
              if (unl_r || lk_set_r || last_r) begin
                locked_r <= lk_set_r; // R12 R13
                {unl_r, lk_set_r} <= '0;
                state_r <= S_PWAIT;
              end else begin
                rsp_valid_r <= 1'b1;
                rsp_data_r <= dq_r;
                state_r <= S_WINDOW;
              end
            end
          end
        end
        // Page stays open; commit before the load window closes
        S_WINDOW: begin
          if (fire) begin
            cnt_r <= '0;
            if (same_page) begin // R01 R02
              // A refused command earlier in the page must not stick
              rsp_err_r <= 1'b0;
              uaddr_r <= CMD_ADDR;
              udata_r <= CMD_DATA;
              last_r <= CMD_LAST;
              addr_r <= CMD_ADDR;
              dq_r <= CMD_DATA;
              ce_n_r <= 1'b0;
              dq_oe_n_r <= 1'b0;
              state_r <= S_WSETUP;
            end else begin
              // Foreign command mid-page: refused, page still open
              rsp_valid_r <= 1'b1;
              rsp_err_r <= 1'b1;
            end
          end else if (cnt_r == eeprom_host_pkg::cnt_t'(
              eeprom_host_pkg::WIN_LIMIT_CYC - 1)) begin // R02
            cnt_r <= '0;
            state_r <= S_PWAIT;
          end
        end
        // Control lines idle so the device begins programming
        S_PWAIT: begin
          if (cnt_r == eeprom_host_pkg::cnt_t'(START_CYC - 1)) begin // R03
            cnt_r <= '0;
            tmo_r <= '0;
            poll_r <= 1'b1;
            addr_r <= uaddr_r;
            ce_n_r <= 1'b0;
            oe_n_r <= 1'b0;
            state_r <= S_RSETUP;
          end
        end
        // Read with access time plus synchroniser latency
        S_RSETUP: begin
          tmo_r <= tmo_r + 1'b1;
          if (cnt_r == eeprom_host_pkg::cnt_t'(eeprom_host_pkg::ACC_CYC +
              eeprom_host_pkg::SYNC_CYC)) begin
            ce_n_r <= 1'b1;
            oe_n_r <= 1'b1;
            cnt_r <= '0;
            if (!poll_r || poll_done) begin // R05 R06
              rsp_valid_r <= 1'b1;
              rsp_data_r <= pins_s[7:0];
              state_r <= S_IDLE;
            end else if (tmo_r >= eeprom_host_pkg::cnt_t'(WC_CYC)) begin
              // Device overran its longest program time
              rsp_valid_r <= 1'b1; // R04
              rsp_err_r <= 1'b1;
              rsp_data_r <= pins_s[7:0];
              state_r <= S_IDLE;
            end else begin
              state_r <= S_PGAP;
            end
          end
        end
        // One deselected cycle between two polls
        S_PGAP: begin
          tmo_r <= tmo_r + 1'b1;
          ce_n_r <= 1'b0;
          oe_n_r <= 1'b0;
          cnt_r <= '0;
          state_r <= S_RSETUP;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Command ready and protect pin
  // ----------------------------------------------------------------
  // Ready drops the cycle after a take and before the window closes
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      ready_r <= 1'b0;
    end else if (fire) begin
      ready_r <= 1'b0;
    end else begin
      ready_r <= prot_r && !HW_PROTECT && (state_r == S_IDLE ||
        (state_r == S_WINDOW && cnt_r < eeprom_host_pkg::cnt_t'(
          eeprom_host_pkg::WIN_LIMIT_CYC - 2)));
    end
  end

  // Protect pin follows the user only between operations
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      prot_r <= 1'b0; // R10
    end else if (state_r == S_IDLE && !fire) begin
      prot_r <= !HW_PROTECT; // R10
    end else begin
      prot_r <= 1'b1; // R11
    end
  end

  assign CMD_READY = ready_r;
  assign RSP_VALID = rsp_valid_r;
  assign RSP_DATA = rsp_data_r;
  assign RSP_ERR = rsp_err_r;
  assign LOCKED = locked_r;
  assign ADDR = addr_r;
  assign DQ_O = dq_r;
  assign DQ_OE_N = dq_oe_n_r;
  assign CE_N = ce_n_r;
  assign OE_N = oe_n_r;
  assign WE_N = we_n_r;
  assign PROTECT_RESET_N = prot_r;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  logic [7:0] wlow_r; // Length of the current strobe-low run
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      wlow_r <= '0;
    end else begin
      wlow_r <= WE_N ? 8'h00 : wlow_r + 8'h01;
    end
  end

  default clocking @(posedge CLK); endclocking
  default disable iff (!NRST);

  strobe_width_a: assert property ( // R07
    $rose(WE_N) |-> wlow_r == 8'(eeprom_host_pkg::WP_CYC))
    else $error("write strobe width wrong");
  no_rd_write_a: assert property ( // R08
    !WE_N |-> OE_N && !CE_N && !DQ_OE_N)
    else $error("write with read enable low or deselected");
  addr_hold_a: assert property ( // R09
    (!WE_N && !$past(WE_N)) |-> $stable(ADDR) && $stable(DQ_O))
    else $error("address or data moved under strobe");
  prot_high_a: assert property ( // R11
    state_r != S_IDLE |-> PROTECT_RESET_N)
    else $error("protect low during an operation");
  idle_desel_a: assert property ( // R15
    state_r inside {S_IDLE, S_PWAIT, S_WINDOW} |-> CE_N && WE_N)
    else $error("device selected while idle");
  page_same_a: assert property ( // R01
    (state_r == S_WINDOW && fire && same_page) |=>
      ADDR[16:eeprom_host_pkg::PAGE_BITS] == $past(page_r) &&
      state_r == S_WSETUP)
    else $error("page load left its page");
  window_bound_a: assert property ( // R02
    state_r == S_WINDOW |-> cnt_r < eeprom_host_pkg::cnt_t'(
      eeprom_host_pkg::WIN_LIMIT_CYC))
    else $error("load window overrun");
  lock_first_a: assert property ( // R12
    (state_r == S_IDLE && fire && CMD_OP == eeprom_host_pkg::OP_LOCK)
      |=> ADDR == eeprom_host_pkg::SEQ_ADDR_A &&
      DQ_O == eeprom_host_pkg::SEQ_D_AA ##1 !WE_N)
    else $error("lock string does not open correctly");
  unlock_third_a: assert property ( // R13
    (state_r == S_WPULSE && unl_r && seq_r == 3'h2) |->
      DQ_O == eeprom_host_pkg::SEQ_D_ERASE &&
      ADDR == eeprom_host_pkg::SEQ_ADDR_A)
    else $error("unlock third byte wrong");
  start_idle_a: assert property ( // R03
    (state_r == S_PWAIT) |-> CE_N && WE_N && OE_N)
    else $error("lines active before programming starts");
  tmo_bound_a: assert property ( // R04
    state_r == S_PGAP |-> tmo_r <= eeprom_host_pkg::cnt_t'(WC_CYC + 64))
    else $error("polling past the program limit");

  page_write_c: cover property (state_r == S_WINDOW && fire && same_page);
  poll_done_c: cover property (state_r == S_RSETUP && poll_r && poll_done
    && cnt_r == eeprom_host_pkg::cnt_t'(eeprom_host_pkg::ACC_CYC + 2));
  lock_c: cover property ($rose(locked_r));
  unlock_c: cover property ($fell(locked_r));

endmodule

// ===== testbench/eeprom_dev_model.sv
// Behavioural page EEPROM standing on the far side of the host
`timescale 1ns/1ps
module eeprom_dev_model #(
  parameter int START_M = 40, // Idle cycles that start programming
  parameter int PROG_M = 400  // Busy cycles of one program
) (
  input wire logic clk,
  input wire logic [16:0] addr,
  input wire logic [7:0] din,
  input wire logic ce_n,
  input wire logic oe_n,
  input wire logic we_n,
  input wire logic prot_n,
  output logic [7:0] dout,
  output logic busy = 1'b0,
  output logic locked = 1'b0,
  output logic prot_fault = 1'b0
);
  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [7:0] mem [logic [16:0]]; // Array, unwritten bytes read 0
  logic [16:0] la_q[$];           // Loaded addresses of the page
  logic [7:0] ld_q[$];            // Loaded data of the page
  logic [16:0] a_lat = '0;        // Address latched at strobe fall
  logic [7:0] last = '0;          // Last byte loaded, for polling
  logic [7:0] hold = '0;          // Last value driven on the bus
  logic [7:0] rd_val;             // Value a read would return
  logic wr;                       // Write strobe seen by the array
  logic wr_d = 1'b0;              // Strobe one cycle back
  logic drv;                      // Device drives the data pins
  int wid = 0;                    // Strobe width in cycles
  int idle = 0;                   // Idle cycles since last byte
  int left = 0;                   // Busy cycles still to run

  // Write only with read enable high and protect released
  assign wr = !ce_n && !we_n && oe_n && prot_n;
  assign drv = !ce_n && !oe_n && we_n;

  // Busy reads show the inverted last byte
  always_comb begin
    if (busy)
      rd_val = ~last;
    else
      rd_val = mem.exists(addr) ? mem[addr] : 8'h00;
  end
  // Released bus shows the inverse of the last value, never a hold
  always_comb dout = drv ? rd_val : ~hold;

  // Step i of the loaded string matches a fixed byte
  function automatic logic hit(input int i, input logic [16:0] a,
                               input logic [7:0] d);
    hit = i < ld_q.size() && la_q[i] == a && ld_q[i] == d;
  endfunction

  // Decode the loaded string, then program what it allows
  task automatic begin_prog();
    int skip;
    logic pre;
    skip = 0;
    pre = hit(0, 17'h0_5555, 8'haa) && hit(1, 17'h0_2aaa, 8'h55);
    if (pre && hit(2, 17'h0_5555, 8'h80) && hit(3, 17'h0_5555, 8'haa)
        && hit(4, 17'h0_2aaa, 8'h55) && hit(5, 17'h0_5555, 8'h20)) begin
      locked <= 1'b0;
      skip = 6;
    end else if (pre && hit(2, 17'h0_5555, 8'ha0)) begin
      locked <= 1'b1;
      skip = 3;
    end else if (locked) begin
      skip = -1;
    end
    if (skip >= 0) begin
      // Only the loaded bytes reach the array
      for (int i = skip; i < ld_q.size(); i++) begin
        mem[la_q[i]] = ld_q[i];
      end
      busy <= 1'b1;
      left <= PROG_M;
    end
    la_q.delete();
    ld_q.delete();
  endtask

  // Pin sampling, byte latching and program timing
  always @(posedge clk) begin
    wr_d <= wr;
    wid <= wr ? wid + 1 : 0;
    if (drv) begin
      hold <= rd_val;
    end
    if (wr && !wr_d) begin
      a_lat <= addr;
    end
    // Pulses of two cycles (20 ns) or less are noise
    if (!wr && wr_d && wid > 2 && !busy) begin
      la_q.push_back(a_lat);
      ld_q.push_back(din);
      last <= din;
    end
    if (!ce_n || !we_n || ld_q.size() == 0) begin
      idle <= 0;
    end else if (idle == START_M && !busy) begin
      begin_prog();
      idle <= 0;
    end else begin
      idle <= idle + 1;
    end
    if (busy) begin
      left <= left - 1;
      busy <= left > 1;
    end
    prot_fault <= prot_fault | (busy && !prot_n);
  end
endmodule

// ===== testbench/eeprom_host_tb_top.sv
// Self-checking bench for the parallel EEPROM host controller
`timescale 1ns/1ps
`define CHK(g, e) check_val(32'(g), 32'(e))
module eeprom_host_tb_top;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  localparam int PROG_M = 400; // Model busy time in cycles
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic cmd_valid = 1'b0;
  eeprom_host_pkg::op_e cmd_op = eeprom_host_pkg::OP_READ;
  logic [16:0] cmd_addr = '0;
  logic [7:0] cmd_data = '0;
  logic cmd_last = 1'b0;
  logic hw_protect = 1'b0;
  logic cmd_ready, rsp_valid, rsp_err, host_locked;
  logic [7:0] rsp_data, dq_o, dq_bus, dev_dq;
  logic [16:0] addr;
  logic dq_oe_n, ce_n, oe_n, we_n, prot_n, rdy_busy_n;
  logic dev_busy, dev_locked, dev_fault;
  int err_total = 0;
  int total_checks = 0;
  int busy_cyc = 0; // Cycles the ready/busy line sat low

  always #5 clk = ~clk;
  // Host wins the bus while it drives; pull-up on ready/busy
  assign dq_bus = dq_oe_n ? dev_dq : dq_o;
  assign rdy_busy_n = dev_busy ? 1'b0 : 1'b1;
  always @(posedge clk) begin
    if (rdy_busy_n === 1'b0) busy_cyc++;
  end

  eeprom_host #(.START_CYC(50), .WC_CYC(2000)) eeprom_host_i (
    .CLK(clk), .NRST(nrst), .CMD_VALID(cmd_valid), .CMD_OP(cmd_op),
    .CMD_ADDR(cmd_addr), .CMD_DATA(cmd_data), .CMD_LAST(cmd_last),
    .HW_PROTECT(hw_protect), .CMD_READY(cmd_ready),
    .RSP_VALID(rsp_valid), .RSP_DATA(rsp_data), .RSP_ERR(rsp_err),
    .LOCKED(host_locked), .ADDR(addr), .DQ_O(dq_o), .DQ_OE_N(dq_oe_n),
    .DQ_I(dq_bus), .CE_N(ce_n), .OE_N(oe_n), .WE_N(we_n),
    .PROTECT_RESET_N(prot_n), .RDY_BUSY_N(rdy_busy_n));

  eeprom_dev_model #(.START_M(40), .PROG_M(PROG_M)) eeprom_dev_model_i (
    .clk(clk), .addr(addr), .din(dq_bus), .ce_n(ce_n), .oe_n(oe_n),
    .we_n(we_n), .prot_n(prot_n), .dout(dev_dq), .busy(dev_busy),
    .locked(dev_locked), .prot_fault(dev_fault));

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic check_val(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e) begin
      err_total++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  // One command: hold until taken, then wait for the answer
  task automatic cmd(input eeprom_host_pkg::op_e op,
                     input logic [16:0] a, input logic [7:0] d,
                     input logic lst);
    int n;
    n = 0;
    cmd_valid <= 1'b1;
    cmd_op <= op;
    cmd_addr <= a;
    cmd_data <= d;
    cmd_last <= lst;
    do @(posedge clk); while (cmd_ready !== 1'b1 && ++n < 5000);
    cmd_valid <= 1'b0;
    do @(posedge clk); while (rsp_valid !== 1'b1 && ++n < 5000);
    // A hang here counts as a mismatch
    if (n >= 5000) `CHK(n, 0);
  endtask

  // Read one byte back and compare it
  task automatic rd_chk(input logic [16:0] a, input logic [7:0] e);
    cmd(eeprom_host_pkg::OP_READ, a, 8'h00, 1'b0);
    `CHK(rsp_data, e);
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  // Page of three bytes at both page edges, foreign read in the window
  task automatic t_page();
    busy_cyc = 0;
    cmd(eeprom_host_pkg::OP_LOAD, 17'h0_0180, 8'h81, 1'b0);
    `CHK(rsp_err, 0);
    cmd(eeprom_host_pkg::OP_READ, 17'h0_0000, 8'h00, 1'b0);
    `CHK(rsp_err, 1);
    cmd(eeprom_host_pkg::OP_LOAD, 17'h0_01ff, 8'h7e, 1'b0);
    cmd(eeprom_host_pkg::OP_LOAD, 17'h0_0181, 8'hc3, 1'b1);
    `CHK(rsp_err, 0);
    `CHK(busy_cyc, PROG_M);
    rd_chk(17'h0_0180, 8'h81);
    rd_chk(17'h0_01ff, 8'h7e);
    rd_chk(17'h0_0181, 8'hc3);
    rd_chk(17'h0_0182, 8'h00);
  endtask

  // Lock, write under protection, then unlock and write plainly
  task automatic t_soft();
    cmd(eeprom_host_pkg::OP_LOCK, 17'h0_0300, 8'h11, 1'b0);
    `CHK(rsp_err, 0);
    `CHK(host_locked, 1);
    `CHK(dev_locked, 1);
    rd_chk(17'h0_0300, 8'h11);
    cmd(eeprom_host_pkg::OP_LOAD, 17'h0_0400, 8'ha5, 1'b1);
    `CHK(rsp_err, 0);
    `CHK(dev_locked, 1);
    rd_chk(17'h0_0400, 8'ha5);
    cmd(eeprom_host_pkg::OP_UNLOCK, 17'h0_0000, 8'h00, 1'b0);
    `CHK(rsp_err, 0);
    `CHK(host_locked, 0);
    `CHK(dev_locked, 0);
    cmd(eeprom_host_pkg::OP_LOAD, 17'h0_0500, 8'h3c, 1'b1);
    rd_chk(17'h0_0500, 8'h3c);
  endtask

  // Hardware protection parks the protect pin and stops commands
  task automatic t_hwprot();
    hw_protect <= 1'b1;
    repeat (4) @(posedge clk);
    `CHK(cmd_ready, 0);
    `CHK(prot_n, 0);
    hw_protect <= 1'b0;
    repeat (4) @(posedge clk);
    `CHK(cmd_ready, 1);
    `CHK(prot_n, 1);
    `CHK(dev_fault, 0);
  endtask

  // ----------------------------------------------------------------
  // Run control
  // ----------------------------------------------------------------
  task automatic close_out();
    $display("Checks %0d, errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // Watchdog: the tests need a few thousand cycles, limit is twenty
  initial begin
    #200_000;
    err_total++;
    close_out();
  end

  initial begin
    repeat (12) @(posedge clk);
    nrst <= 1'b1;
    repeat (3) @(posedge clk);
    t_page();
    t_soft();
    t_hwprot();
    close_out();
  end
endmodule
